// ==== verilog/fifo_port_pkg.sv ====
// ==========================================================================
// Shared constants and carriers for the three-port buffer.
// ==========================================================================
package fifo_port_pkg;

  // Port widths: port A carries whole words, ports B and C carry halves.
  localparam int A_W      = 36;
  localparam int H_W      = 18;
  localparam int CNT_W    = 9;

  // Each FIFO holds this many 36-bit words.
  localparam logic [CNT_W-1:0] DEPTH     = 9'h100;

  // Every threshold register starts at an offset of 8 words.
  localparam logic [CNT_W-1:0] THR_RESET = 9'h008;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_A_EMPTY_THR = 8'h00;
  localparam logic [7:0] OFF_B_EMPTY_THR = 8'h04;
  localparam logic [7:0] OFF_A_FULL_THR  = 8'h08;
  localparam logic [7:0] OFF_C_FULL_THR  = 8'h0C;
  localparam logic [7:0] OFF_STATUS      = 8'h10;

  // Field positions inside the status word.
  localparam int ST_FWFT_BIT = 0;
  localparam int ST_BIG_BIT  = 1;
  localparam int ST_CNT1_LSB = 8;
  localparam int ST_CNT2_LSB = 20;

  // All pin inputs that arrive from outside the core clock domain.
  typedef struct packed {
    logic           clk_a;
    logic           clk_b;
    logic           clk_c;
    logic           a_sel_n;
    logic           a_qual;
    logic           a_write;
    logic           b_sel_n;
    logic           b_rd_en;
    logic           c_wr_en;
    logic           order;
    logic           mres_n;
    logic [A_W-1:0] a_data;
    logic [H_W-1:0] c_data;
  } pins_t;

  // The four programmable flag thresholds.
  typedef struct packed {
    logic [CNT_W-1:0] a_empty;
    logic [CNT_W-1:0] b_empty;
    logic [CNT_W-1:0] a_full;
    logic [CNT_W-1:0] c_full;
  } thr_t;

endpackage : fifo_port_pkg

// ==== verilog/triple_port_fifo.sv ====
// Summary of operation
// (R01) A near-empty low when FIFO2 count <= threshold.
// (R02) B near-empty low when FIFO1 count <= threshold.
// (R03) A near-full low when FIFO1 vacancies <= threshold.
// (R04) C near-full low when FIFO2 vacancies <= threshold.
// (R05) Order pin high at reset: big-endian halves.
// (R06) Order pin low at reset: little-endian halves.
// (R07) After reset order pin picks timing mode.
// (R08) Outside party keeps order pin static afterwards.
// (R09) Port A flags change only on A edges.
// (R10) Port B flags change only on B edges.
// (R11) Port C flags change only on C edges.
// (R12) Port clocks may be asynchronous or coincident.
// (R13) Port A transfers need select low; else float.
// (R14) Port B reads need select low; else float.
// (R15) Outside party raises qualifier for A transfers.
// (R16) Standard mode: A flag shows FIFO2 not empty.
// (R17) Fall-through mode: A flag shows output valid.
// (R18) Standard mode: B flag shows FIFO1 not empty.
// (R19) Fall-through mode: B flag shows output valid.
// (R20) A full flag: FIFO1 full or space free.
// (R21) C full flag: FIFO2 full or space free.
// (R22) Port A 36 bits two-way, B/C 18 bits.
// (R23) Fall-through presents first word without read.
// (R24) Flags pass two synchroniser stages per port.
// (R25) Master reset release latches the endian choice.
// (R26) Full/empty flags active low, ready active high.
`timescale 1ns/1ps

module triple_port_fifo (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // APB register slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Port pins, all asynchronous to the core clock.
  input  wire logic                          port_a_clock,
  input  wire logic                          port_b_clock,
  input  wire logic                          port_c_clock,
  input  wire logic                          port_a_select_n,
  input  wire logic                          port_a_xfer_qualifier,
  input  wire logic                          port_a_write,
  input  wire logic                          port_b_select_n,
  input  wire logic                          port_b_read_en,
  input  wire logic                          port_c_write_en,
  input  wire logic                          order_or_fallthru_pin,
  input  wire logic                          fifo1_master_reset_n,
  input  wire logic [fifo_port_pkg::A_W-1:0] port_a_data_in,
  output logic      [fifo_port_pkg::A_W-1:0] port_a_data_out,
  output logic                               port_a_data_oe,
  output logic      [fifo_port_pkg::H_W-1:0] port_b_data,
  output logic                               port_b_data_oe,
  input  wire logic [fifo_port_pkg::H_W-1:0] port_c_data,
  // Flag pins.
  output logic                               a_side_empty_n_or_out_ready,
  output logic                               b_side_empty_n_or_out_ready,
  output logic                               a_side_full_n_or_in_ready,
  output logic                               c_side_full_n_or_in_ready,
  output logic                               a_side_near_empty_n,
  output logic                               b_side_near_empty_n,
  output logic                               a_side_near_full_n,
  output logic                               c_side_near_full_n
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Half of a word that leaves or enters first, by byte order.
  function automatic logic [fifo_port_pkg::H_W-1:0] first_half(
    input logic [fifo_port_pkg::A_W-1:0] word,
    input logic                          big);
    first_half = big ? word[35:18] : word[17:0];
  endfunction : first_half

  // Half of a word that leaves or enters second, by byte order.
  function automatic logic [fifo_port_pkg::H_W-1:0] second_half(
    input logic [fifo_port_pkg::A_W-1:0] word,
    input logic                          big);
    second_half = big ? word[17:0] : word[35:18];
  endfunction : second_half

  // Near-empty is active low: low while the count is at or below the limit.
  function automatic logic near_empty_n(
    input logic [fifo_port_pkg::CNT_W-1:0] cnt,
    input logic [fifo_port_pkg::CNT_W-1:0] thr);
    near_empty_n = (cnt > thr);
  endfunction : near_empty_n

  // Near-full is active low: low while free space is at or below the limit.
  function automatic logic near_full_n(
    input logic [fifo_port_pkg::CNT_W-1:0] cnt,
    input logic [fifo_port_pkg::CNT_W-1:0] thr);
    near_full_n = ((fifo_port_pkg::DEPTH - cnt) > thr);
  endfunction : near_full_n

  // ========================================================================
  // Pin synchronisers and port clock edge detection
  // ========================================================================

  fifo_port_pkg::pins_t pins_w;   // Raw pins gathered into one carrier.
  fifo_port_pkg::pins_t sync1_r;  // First stage, read only by the second.
  fifo_port_pkg::pins_t sync2_r;  // Second stage, safe for logic.
  logic [2:0]           clk_prev_r;  // Port clocks one cycle after sync2.
  logic                 mres_prev_r; // Master reset level one cycle ago.

  assign pins_w = '{clk_a: port_a_clock, clk_b: port_b_clock, clk_c: port_c_clock,
                    a_sel_n: port_a_select_n, a_qual: port_a_xfer_qualifier,
                    a_write: port_a_write, b_sel_n: port_b_select_n,
                    b_rd_en: port_b_read_en, c_wr_en: port_c_write_en,
                    order: order_or_fallthru_pin, mres_n: fifo1_master_reset_n,
                    a_data: port_a_data_in, c_data: port_c_data};

  // Every pin passes two flops, so the port clocks may run asynchronously
  // or in step with each other; each port edge becomes one core pulse.
  always_ff @(posedge core_clk) begin // R12 R24
    if (!rst_n) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      clk_prev_r  <= 3'h0;
      mres_prev_r <= 1'b0;
    end else begin
      sync1_r     <= pins_w;
      sync2_r     <= sync1_r;
      clk_prev_r  <= {sync2_r.clk_a, sync2_r.clk_b, sync2_r.clk_c};
      mres_prev_r <= sync2_r.mres_n;
    end
  end

  logic a_edge;  // Rising edge of the port A clock.
  logic b_edge;  // Rising edge of the port B clock.
  logic c_edge;  // Rising edge of the port C clock.
  logic mres;    // Master reset held, data paths cleared.

  assign a_edge = sync2_r.clk_a & ~clk_prev_r[2];
  assign b_edge = sync2_r.clk_b & ~clk_prev_r[1];
  assign c_edge = sync2_r.clk_c & ~clk_prev_r[0];
  assign mres   = ~sync2_r.mres_n;

  // ========================================================================
  // Configuration latched around master reset
  // ========================================================================

  logic big_r;   // Big-endian half order.
  logic fwft_r;  // Fall-through timing selected.

  // Byte order is caught on the release edge; timing mode follows the pin
  // afterwards, which relies on the far side holding it steady.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      big_r  <= 1'b0;
      fwft_r <= 1'b0;
    end else if (sync2_r.mres_n && !mres_prev_r) begin
      big_r  <= sync2_r.order; // R05 R06 R25
    end else if (sync2_r.mres_n) begin
      fwft_r <= ~sync2_r.order; // R07 R08
    end
  end

  // ========================================================================
  // APB register file
  // ========================================================================

  fifo_port_pkg::thr_t thr_r;  // Programmable flag thresholds.
  logic [8:0]          cnt1;   // Words held in FIFO1.
  logic [8:0]          cnt2;   // Words held in FIFO2.

  // One wait state: the access phase is answered on its second cycle, which
  // keeps read data and the error flag straight from flops.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      thr_r   <= '{default: fifo_port_pkg::THR_RESET};
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h0000_0000;
        case (paddr)
          fifo_port_pkg::OFF_A_EMPTY_THR: begin
            if (pwrite) thr_r.a_empty <= pwdata[8:0];
            else prdata[8:0] <= thr_r.a_empty;
          end
          fifo_port_pkg::OFF_B_EMPTY_THR: begin
            if (pwrite) thr_r.b_empty <= pwdata[8:0];
            else prdata[8:0] <= thr_r.b_empty;
          end
          fifo_port_pkg::OFF_A_FULL_THR: begin
            if (pwrite) thr_r.a_full <= pwdata[8:0];
            else prdata[8:0] <= thr_r.a_full;
          end
          fifo_port_pkg::OFF_C_FULL_THR: begin
            if (pwrite) thr_r.c_full <= pwdata[8:0];
            else prdata[8:0] <= thr_r.c_full;
          end
          fifo_port_pkg::OFF_STATUS: begin
            // The status word is read-only; writes are quietly dropped.
            prdata[fifo_port_pkg::ST_FWFT_BIT]      <= fwft_r;
            prdata[fifo_port_pkg::ST_BIG_BIT]       <= big_r;
            prdata[fifo_port_pkg::ST_CNT1_LSB +: 9] <= cnt1;
            prdata[fifo_port_pkg::ST_CNT2_LSB +: 9] <= cnt2;
          end
          default: begin
            // Unmapped offsets answer with an error and zero data.
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ========================================================================
  // FIFO1: port A writes words, port B reads halves
  // ========================================================================

  logic [35:0] mem1 [0:255];   // FIFO1 storage.
  logic [8:0]  wptr1_r;        // FIFO1 write pointer, one wrap bit.
  logic [8:0]  rptr1_r;        // FIFO1 read pointer, one wrap bit.
  logic [35:0] hold1_r;        // Word whose second half is still pending.
  logic        pend1_r;        // Second half of hold1_r not yet sent.
  logic        b_valid_r;      // Port B output register holds live data.
  logic        a_wr;           // Accepted port A write.
  logic        b_rd;           // Port B read request.
  logic        b_load;         // Port B output register reloads.

  assign cnt1   = wptr1_r - rptr1_r;
  assign a_wr   = a_edge && !sync2_r.a_sel_n && sync2_r.a_qual // R13 R15
                  && sync2_r.a_write && (cnt1 != fifo_port_pkg::DEPTH);
  assign b_rd   = b_edge && !sync2_r.b_sel_n && sync2_r.b_rd_en; // R14
  // Fall-through refills an empty output register unasked.
  assign b_load = b_edge && (fwft_r ? (!b_valid_r || b_rd) : b_rd); // R23

  // Port A write side of FIFO1; full writes are ignored.
  always_ff @(posedge core_clk) begin
    if (!rst_n || mres) begin
      wptr1_r <= 9'h000;
    end else if (a_wr) begin
      mem1[wptr1_r[7:0]] <= sync2_r.a_data;
      wptr1_r            <= wptr1_r + 9'h001;
    end
  end

  // Port B read side: each word leaves as two halves in latched order.
  always_ff @(posedge core_clk) begin
    if (!rst_n || mres) begin
      rptr1_r     <= 9'h000;
      hold1_r     <= 36'h0_0000_0000;
      pend1_r     <= 1'b0;
      b_valid_r   <= 1'b0;
      port_b_data <= 18'h0_0000;
    end else if (b_load) begin
      if (pend1_r) begin
        port_b_data <= second_half(hold1_r, big_r); // R05 R06
        pend1_r     <= 1'b0;
        b_valid_r   <= 1'b1;
      end else if (cnt1 != 9'h000) begin
        hold1_r     <= mem1[rptr1_r[7:0]];
        port_b_data <= first_half(mem1[rptr1_r[7:0]], big_r); // R05 R06
        rptr1_r     <= rptr1_r + 9'h001;
        pend1_r     <= 1'b1;
        b_valid_r   <= 1'b1;
      end else if (fwft_r) begin
        b_valid_r   <= 1'b0;
      end
    end
  end

  // ========================================================================
  // FIFO2: port C writes halves, port A reads words
  // ========================================================================

  logic [35:0] mem2 [0:255];   // FIFO2 storage.
  logic [8:0]  wptr2_r;        // FIFO2 write pointer, one wrap bit.
  logic [8:0]  rptr2_r;        // FIFO2 read pointer, one wrap bit.
  logic [17:0] hold2_r;        // First half of the word being gathered.
  logic        pend2_r;        // A first half is waiting for its partner.
  logic        a_valid_r;      // Port A output register holds live data.
  logic        c_wr;           // Accepted port C half write.
  logic        a_rd;           // Port A read request.
  logic        a_load;         // Port A output register reloads.

  assign cnt2   = wptr2_r - rptr2_r;
  assign c_wr   = c_edge && sync2_r.c_wr_en && (cnt2 != fifo_port_pkg::DEPTH);
  assign a_rd   = a_edge && !sync2_r.a_sel_n && sync2_r.a_qual // R13 R15
                  && !sync2_r.a_write;
  assign a_load = a_edge && (fwft_r ? (!a_valid_r || a_rd) : a_rd); // R23

  // Port C gathers two halves, then stores one word in latched order.
  always_ff @(posedge core_clk) begin
    if (!rst_n || mres) begin
      wptr2_r <= 9'h000;
      hold2_r <= 18'h0_0000;
      pend2_r <= 1'b0;
    end else if (c_wr) begin
      if (!pend2_r) begin
        hold2_r <= sync2_r.c_data;
        pend2_r <= 1'b1;
      end else begin
        mem2[wptr2_r[7:0]] <= big_r ? {hold2_r, sync2_r.c_data} // R05 R06
                                    : {sync2_r.c_data, hold2_r};
        wptr2_r            <= wptr2_r + 9'h001;
        pend2_r            <= 1'b0;
      end
    end
  end

  // Port A read side of FIFO2; an empty read leaves the output as it was.
  always_ff @(posedge core_clk) begin
    if (!rst_n || mres) begin
      rptr2_r         <= 9'h000;
      a_valid_r       <= 1'b0;
      port_a_data_out <= 36'h0_0000_0000;
    end else if (a_load) begin
      if (cnt2 != 9'h000) begin
        port_a_data_out <= mem2[rptr2_r[7:0]];
        rptr2_r         <= rptr2_r + 9'h001;
        a_valid_r       <= 1'b1;
      end else if (fwft_r) begin
        a_valid_r       <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Output enables and flags
  // ========================================================================

  // Data pins float unless selected; port A drives only while reading.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      port_a_data_oe <= 1'b0;
      port_b_data_oe <= 1'b0;
    end else begin
      port_a_data_oe <= !sync2_r.a_sel_n && !sync2_r.a_write; // R13 R22
      port_b_data_oe <= !sync2_r.b_sel_n; // R14 R22
    end
  end

  // Port A flags move only on port A edges.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      a_side_empty_n_or_out_ready <= 1'b0;
      a_side_full_n_or_in_ready   <= 1'b0;
      a_side_near_empty_n         <= 1'b0;
      a_side_near_full_n          <= 1'b1;
    end else if (a_edge) begin // R09
      a_side_empty_n_or_out_ready <= fwft_r ? a_valid_r : (cnt2 != 9'h000); // R16 R17 R26
      a_side_full_n_or_in_ready   <= (cnt1 != fifo_port_pkg::DEPTH); // R20 R26
      a_side_near_empty_n         <= near_empty_n(cnt2, thr_r.a_empty); // R01
      a_side_near_full_n          <= near_full_n(cnt1, thr_r.a_full); // R03
    end
  end

  // Port B flags move only on port B edges.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      b_side_empty_n_or_out_ready <= 1'b0;
      b_side_near_empty_n         <= 1'b0;
    end else if (b_edge) begin // R10
      b_side_empty_n_or_out_ready <= fwft_r ? b_valid_r
                                            : ((cnt1 != 9'h000) || pend1_r); // R18 R19
      b_side_near_empty_n         <= near_empty_n(cnt1, thr_r.b_empty); // R02
    end
  end

  // Port C flags move only on port C edges.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      c_side_full_n_or_in_ready <= 1'b0;
      c_side_near_full_n        <= 1'b1;
    end else if (c_edge) begin // R11
      c_side_full_n_or_in_ready <= (cnt2 != fifo_port_pkg::DEPTH); // R21 R26
      c_side_near_full_n        <= near_full_n(cnt2, thr_r.c_full); // R04
    end
  end

  // ========================================================================
  // Assertions
  // ========================================================================

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_A_NEAR_EMPTY: assert property (a_edge |=> // R01
    a_side_near_empty_n == ($past(cnt2) > $past(thr_r.a_empty)))
    else $error("A near-empty flag disagrees with FIFO2 count.");
  AST_B_NEAR_EMPTY: assert property (b_edge |=> // R02
    b_side_near_empty_n == ($past(cnt1) > $past(thr_r.b_empty)))
    else $error("B near-empty flag disagrees with FIFO1 count.");
  AST_A_NEAR_FULL: assert property (a_edge |=> // R03
    a_side_near_full_n == ((9'h100 - $past(cnt1)) > $past(thr_r.a_full)))
    else $error("A near-full flag disagrees with FIFO1 space.");
  AST_C_NEAR_FULL: assert property (c_edge |=> // R04
    c_side_near_full_n == ((9'h100 - $past(cnt2)) > $past(thr_r.c_full)))
    else $error("C near-full flag disagrees with FIFO2 space.");
  AST_A_FLAGS_HOLD: assert property (!a_edge |=> // R09
    $stable(a_side_near_empty_n) && $stable(a_side_full_n_or_in_ready))
    else $error("Port A flag moved without a port A edge.");
  AST_B_FLAGS_HOLD: assert property (!b_edge |=> $stable(b_side_empty_n_or_out_ready)) // R10
    else $error("Port B flag moved without a port B edge.");
  AST_C_FLAGS_HOLD: assert property (!c_edge |=> $stable(c_side_near_full_n)) // R11
    else $error("Port C flag moved without a port C edge.");
  AST_ENDIAN_LATCH: assert property (sync2_r.mres_n && !mres_prev_r |=> // R25
    big_r == $past(sync2_r.order))
    else $error("Byte order not caught at reset release.");
  AST_A_FLOAT: assert property (sync2_r.a_sel_n |=> !port_a_data_oe [*1]) // R13
    else $error("Port A driven while deselected.");
  AST_NO_OVERFLOW: assert property (cnt1 <= 9'h100 && cnt2 <= 9'h100) // R20
    else $error("FIFO count passed its depth.");
  AST_FWFT_READY: assert property (a_edge && fwft_r && fwft_r ##1 fwft_r |-> // R17
    a_side_empty_n_or_out_ready == $past(a_valid_r))
    else $error("A ready flag does not follow output validity.");

  COV_A_WRITE:  cover property (a_wr ##[1:1000] b_rd);
  COV_C_TO_A:   cover property (c_wr ##[1:1000] a_rd);
  COV_FIFO1_FULL: cover property (cnt1 == 9'h100);

endmodule : triple_port_fifo

// ==== tb/port_clocks.sv ====
`timescale 1ns/1ps
// ==========================================
// Far-side buses: free-running port clocks.
module port_clocks (
  output logic port_a_clock,
  output logic port_b_clock,
  output logic port_c_clock
);
  // Unrelated periods keep the three domains asynchronous.
  initial begin
    port_a_clock = 1'b0;
    forever #100 port_a_clock = ~port_a_clock;
  end
  initial begin
    port_b_clock = 1'b0;
    forever #125 port_b_clock = ~port_b_clock;
  end
  initial begin
    port_c_clock = 1'b0;
    forever #150 port_c_clock = ~port_c_clock;
  end
endmodule : port_clocks

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
// ==========================================
// Bench: APB register access, then port traffic in both modes.
module testbench;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pac, pbc, pcc, a_sel_n, a_qual, a_wr, b_sel_n, b_rd, c_wr, order, mres_n;
  logic [35:0] a_din, a_dout;
  logic [17:0] b_dat, c_dat;
  logic        a_oe, b_oe, a_ef, b_ef, a_ff, c_ff, a_ae, b_ae, a_af, c_af;
  wire  [2:0]  pclk = {pcc, pbc, pac};
  int          err_total, checks_done;
  port_clocks i_clk (.port_a_clock(pac), .port_b_clock(pbc), .port_c_clock(pcc));
  triple_port_fifo i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_clock(pac), .port_b_clock(pbc),
    .port_c_clock(pcc), .port_a_select_n(a_sel_n), .port_a_xfer_qualifier(a_qual),
    .port_a_write(a_wr), .port_b_select_n(b_sel_n), .port_b_read_en(b_rd),
    .port_c_write_en(c_wr), .order_or_fallthru_pin(order), .fifo1_master_reset_n(mres_n),
    .port_a_data_in(a_din), .port_a_data_out(a_dout), .port_a_data_oe(a_oe),
    .port_b_data(b_dat), .port_b_data_oe(b_oe), .port_c_data(c_dat),
    .a_side_empty_n_or_out_ready(a_ef), .b_side_empty_n_or_out_ready(b_ef),
    .a_side_full_n_or_in_ready(a_ff), .c_side_full_n_or_in_ready(c_ff),
    .a_side_near_empty_n(a_ae), .b_side_near_empty_n(b_ae),
    .a_side_near_full_n(a_af), .c_side_near_full_n(c_af));
  // The core clock, 25 ns period.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Compares any result; case inequality lets no unknown pass.
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for n rising edges of one port clock.
  task automatic edges(input int p, input int n);
    repeat (n) @(posedge pclk[p]);
    @(posedge core_clk);
  endtask : edges
  // Holds the controls past the core's capture of one port edge.
  task automatic xfer(input int p);
    edges(p, 1);
    repeat (5) @(posedge core_clk);
  endtask : xfer
  // Master reset; the order pin then stays put, as the mode needs.
  task automatic mreset(input logic o);
    order  <= o;
    mres_n <= 1'b0;
    edges(2, 5);
    mres_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : mreset
  // Two port C halves; the data lines flip once released.
  task automatic cpair(input logic [17:0] h0, input logic [17:0] h1);
    c_wr  <= 1'b1;
    c_dat <= h0;
    xfer(2);
    c_dat <= h1;
    xfer(2);
    c_wr  <= 1'b0;
    c_dat <= ~h1;
  endtask : cpair
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // A hang ends here; the tests need far less than this.
  initial begin
    #300000;
    err_total++;
    test_done();
  end
  // Main sequence.
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, a_qual, a_wr, b_rd, c_wr} = '0;
    {a_sel_n, b_sel_n, order, mres_n} = 4'hF;
    a_din = 36'h0;
    c_dat = 18'h0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, fifo_port_pkg::OFF_B_EMPTY_THR, 32'h0);
    chk("thr reset", 36'h8, rd);
    apb(1'b1, fifo_port_pkg::OFF_A_EMPTY_THR, 32'h0);
    apb(1'b1, fifo_port_pkg::OFF_A_FULL_THR, 32'h100);
    apb(1'b0, fifo_port_pkg::OFF_A_FULL_THR, 32'h0);
    chk("a_full thr", 36'h100, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", 36'h1, {35'h0, er});
    mreset(1'b1);
    apb(1'b0, fifo_port_pkg::OFF_STATUS, 32'h0);
    chk("status big std", 36'h2, rd);
    edges(0, 3);
    chk("a empty", 36'h0, a_ef);
    chk("a near empty", 36'h0, a_ae);
    chk("a near full", 36'h0, a_af);
    chk("a full", 36'h1, a_ff);
    chk("b empty", 36'h0, b_ef);
    cpair(18'h12345, 18'h0ABCD);
    edges(0, 3);
    chk("a not empty", 36'h1, a_ef);
    chk("a near empty off", 36'h1, a_ae);
    a_sel_n <= 1'b0;
    a_qual  <= 1'b1;
    xfer(0);
    chk("a oe", 36'h1, a_oe);
    chk("a word", 36'h48D14ABCD, a_dout);
    a_din   <= 36'h987654321;
    a_wr    <= 1'b1;
    xfer(0);
    a_sel_n <= 1'b1;
    a_din   <= 36'h6789ABCDE;
    edges(0, 2);
    // Read direction while deselected: only the select can keep the pins off.
    a_wr    <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("a float", 36'h0, a_oe);
    edges(1, 3);
    chk("b not empty", 36'h1, b_ef);
    chk("b near empty", 36'h0, b_ae);
    b_sel_n <= 1'b0;
    b_rd    <= 1'b1;
    xfer(1);
    chk("b oe", 36'h1, b_oe);
    chk("b first half", 36'h261D9, b_dat);
    xfer(1);
    chk("b second half", 36'h14321, b_dat);
    b_sel_n <= 1'b1;
    b_rd    <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("b float", 36'h0, b_oe);
    // The deselected port A write must not have reached FIFO1.
    edges(1, 2);
    chk("b drained", 36'h0, b_ef);
    mreset(1'b0);
    apb(1'b0, fifo_port_pkg::OFF_STATUS, 32'h0);
    chk("status little ft", 36'h1, rd);
    cpair(18'h11111, 18'h22222);
    edges(0, 4);
    chk("a out ready", 36'h1, a_ef);
    chk("a fell through", 36'h888891111, a_dout);
    chk("c in ready", 36'h1, c_ff);
    chk("c near full", 36'h1, c_af);
    // One port A word falls through to port B, low half first.
    a_din   <= 36'h123456789;
    a_wr    <= 1'b1;
    a_sel_n <= 1'b0;
    xfer(0);
    a_sel_n <= 1'b1;
    edges(1, 3);
    chk("b out ready", 36'h1, b_ef);
    chk("b fell through", 36'h16789, b_dat);
    test_done();
  end
endmodule : testbench
